// ### rtl/ltm_pkg.sv
// Constants, types and shared helpers for the localizer tone modulator
package ltm_pkg;
  // Depths are in 0.01 % units, 16'h2710 is 100 %
  localparam int DEPTH_W = 16;
  localparam logic [15:0] LTM_FULL_DEPTH = 16'h2710;
  localparam int ACC_W = 32;
  localparam int SIN_W = 12;
  localparam int SIN_SHIFT = 11;
  localparam int PH_IDX_W = 6;
  localparam int OUT_W = 16;
  localparam int SUM_W = 31;
  // Indicator current, 0.01 uA per lsb: 9.6775 per depth lsb in Q10
  localparam int CUR_W = 25;
  localparam logic [15:0] LTM_CUR_MUL = 16'h26B6;
  localparam int CUR_SHIFT = 10;
  // Inverse of the above in Q16
  localparam logic [15:0] LTM_CUR_INV = 16'h1A74;
  localparam int CUR_INV_SHIFT = 16;
  // Decibels, 0.01 dB per lsb, from log2 in Q8 times 20*log10(2)
  localparam logic [15:0] LTM_DB_MUL = 16'h025A;
  localparam int LOG_FRAC = 8;
  localparam int LOG_MSB = 16;
  localparam int DB_SHIFT = 8;
  localparam logic [15:0] LTM_DB_MAX = 16'hFFFF;
  localparam logic [3:0] LTM_SOLVE_TOP = 4'hF;
  // Standardized difference values for list stepping
  localparam int STEP_N = 4;
  localparam logic [1:0] LTM_STEP_LAST = 2'h3;
  localparam logic [15:0] LTM_STEP_LIST [STEP_N] =
    '{16'h0000, 16'h009B, 16'h03A2, 16'h060E};
  // Morse timing, lengths counted in time units
  localparam int LEN_W = 10;
  localparam int LONG_W = 12;
  localparam int LETTER_W = 5;
  localparam int CODE_N = 4;
  localparam int PERIOD_W = 16;
  localparam logic [LONG_W-1:0] LTM_STD_MUL = 12'h003;
  // Time unit of the keyer is 1 ms
  localparam int TICK_TIME_NS = 1_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_W = $clog2(TICK_CYCLES);

  typedef enum logic [1:0] {
    LTM_MODE_NORM  = 2'b00,
    LTM_MODE_LEFT  = 2'b01,
    LTM_MODE_RIGHT = 2'b10
  } ltm_mode_t;

  typedef struct packed {
    logic [ACC_W-1:0]   left_inc;   // 90 Hz lobe tuning word
    logic [ACC_W-1:0]   right_inc;  // 150 Hz lobe tuning word
    logic [DEPTH_W-1:0] phase;      // Left offset, fraction of a cycle
  } ltm_lobe_cfg_t;

  typedef struct packed {
    logic                       en;
    logic                       user_schema;
    logic [CODE_N*LETTER_W-1:0] code;      // Letter 1..26, slot 0 first
    logic [LEN_W-1:0]           dot;
    logic [LEN_W-1:0]           dash;
    logic [LEN_W-1:0]           sym_space;
    logic [LEN_W-1:0]           letter_space;
    logic [PERIOD_W-1:0]        period;
    logic [DEPTH_W-1:0]         depth;
    logic [ACC_W-1:0]           inc;
  } ltm_ident_cfg_t;

  // Quarter-wave sine table, 64 points per cycle
  function automatic logic signed [SIN_W-1:0] ltm_sine(input logic [PH_IDX_W-1:0] ph);
    logic [3:0]  idx;
    logic [10:0] mag;
    idx = ph[4] ? ~ph[3:0] : ph[3:0];
    case (idx)
      4'h0: mag = 11'h064;  4'h1: mag = 11'h12C;
      4'h2: mag = 11'h1F1;  4'h3: mag = 11'h2B2;
      4'h4: mag = 11'h36B;  4'h5: mag = 11'h41C;
      4'h6: mag = 11'h4C3;  4'h7: mag = 11'h55F;
      4'h8: mag = 11'h5ED;  4'h9: mag = 11'h66C;
      4'hA: mag = 11'h6DC;  4'hB: mag = 11'h73B;
      4'hC: mag = 11'h787;  4'hD: mag = 11'h7C2;
      4'hE: mag = 11'h7E9;  default: mag = 11'h7FD;
    endcase
    ltm_sine = ph[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction
endpackage

// ### rtl/ltm_morse_keyer.sv
// Morse keyer that gates the identification tone
module ltm_morse_keyer
  import ltm_pkg::*;
(
  input  wire logic           mclk,  // Sample clock
  input  wire logic           rst,   // Sync reset, active high
  input  wire logic           tick,  // One-cycle time unit pulse
  input  wire ltm_ident_cfg_t cfg,   // Identification settings
  output logic                key    // High while keyed down
);
  typedef enum logic [1:0] {
    KS_MARK    = 2'b00,
    KS_SYM_GAP = 2'b01,
    KS_LET_GAP = 2'b10,
    KS_WAIT    = 2'b11
  } ltm_key_state_t;

  ltm_key_state_t      state_reg;
  logic [1:0]          letter_reg;
  logic [1:0]          sym_reg;
  logic [LONG_W-1:0]   cnt_reg;
  logic [PERIOD_W-1:0] per_reg;
  logic [1:0]          nxt_letter;
  logic [6:0]          cur;
  logic [LONG_W-1:0]   dot_len, dash_len, sym_len, let_len, phase_len;
  logic                no_code, done, last_sym, more, restart;

  // Length and pattern of one letter, pattern bit set for a dash
  function automatic logic [6:0] morse(input logic [LETTER_W-1:0] l);
    case (l)
      5'h01: morse = 7'h22;  5'h02: morse = 7'h41;  5'h03: morse = 7'h45;
      5'h04: morse = 7'h31;  5'h05: morse = 7'h10;  5'h06: morse = 7'h44;
      5'h07: morse = 7'h33;  5'h08: morse = 7'h40;  5'h09: morse = 7'h20;
      5'h0A: morse = 7'h4E;  5'h0B: morse = 7'h35;  5'h0C: morse = 7'h42;
      5'h0D: morse = 7'h23;  5'h0E: morse = 7'h21;  5'h0F: morse = 7'h37;
      5'h10: morse = 7'h46;  5'h11: morse = 7'h4B;  5'h12: morse = 7'h32;
      5'h13: morse = 7'h30;  5'h14: morse = 7'h11;  5'h15: morse = 7'h34;
      5'h16: morse = 7'h48;  5'h17: morse = 7'h36;  5'h18: morse = 7'h49;
      5'h19: morse = 7'h4D;  5'h1A: morse = 7'h43;  default: morse = 7'h00;
    endcase
  endfunction

  // Standard scheme derives all lengths from the dot
  assign dot_len  = {2'b00, cfg.dot};
  assign dash_len = cfg.user_schema ? {2'b00, cfg.dash} : dot_len * LTM_STD_MUL;
  assign sym_len  = cfg.user_schema ? {2'b00, cfg.sym_space} : dot_len;
  assign let_len  = cfg.user_schema ? {2'b00, cfg.letter_space} : dot_len * LTM_STD_MUL;

  // Sequencing terms
  assign nxt_letter = letter_reg + 2'h1;
  assign cur        = morse(cfg.code[letter_reg*LETTER_W +: LETTER_W]);
  assign no_code    = cfg.code == '0;
  assign last_sym   = ({1'b0, sym_reg} + 3'h1) >= cur[6:4];
  assign more       = (letter_reg != LTM_STEP_LAST) &&
                      (cfg.code[nxt_letter*LETTER_W +: LETTER_W] != '0);
  always_comb begin
    case (state_reg)
      KS_MARK:    phase_len = cur[sym_reg] ? dash_len : dot_len;
      KS_SYM_GAP: phase_len = sym_len;
      KS_LET_GAP: phase_len = let_len;
      default:    phase_len = '1;
    endcase
  end
  assign done    = tick && ((cnt_reg + 12'h001) >= phase_len);
  assign restart = !cfg.en || no_code || (state_reg == KS_WAIT && tick &&
                   ({16'h0000, per_reg} + 32'h0000_0001) >= {16'h0000, cfg.period});

  // Symbol and letter sequencer, repeats once per period
  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      state_reg  <= KS_MARK;
      letter_reg <= '0;
      sym_reg    <= '0;
    end else if (done) begin
      case (state_reg)
        KS_MARK:    state_reg <= !last_sym ? KS_SYM_GAP : (more ? KS_LET_GAP : KS_WAIT);
        KS_SYM_GAP: begin
          state_reg <= KS_MARK;
          sym_reg   <= sym_reg + 2'h1;
        end
        KS_LET_GAP: begin
          state_reg  <= KS_MARK;
          letter_reg <= nxt_letter;
          sym_reg    <= '0;
        end
        default:    state_reg <= KS_WAIT;
      endcase
    end
  end

  // Element and period timers
  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      cnt_reg <= '0;
      per_reg <= '0;
    end else if (tick) begin
      cnt_reg <= done ? '0 : cnt_reg + 12'h001;
      per_reg <= (per_reg == '1) ? per_reg : per_reg + 16'h0001;
    end
  end

  // No code set means steady key down
  always_ff @(posedge mclk) begin
    if (rst) begin
      key <= 1'b0;
    end else begin
      key <= no_code || (state_reg == KS_MARK);
    end
  end
endmodule

// ### rtl/ltm_localizer_tone_modulator.sv
// Localizer baseband modulator: lobe tones, depth difference, ident tone
//
// Notes on behaviour
// - Normal mode: both lobe tones plus ident
// - Left-only mode: 90 Hz tone, half-sum depth
// - Right-only mode: 150 Hz tone, half-sum depth
// - Steering direction flips difference sign and dominance
// - Polarity selects which tone is subtracted
// - Sum setting is arithmetic sum of lobe depths
// - Fixed coupling keeps difference on sum change
// - Coupled mode rescales difference, dB held constant
// - Current is difference times 967.75 uA
// - dB form is 20log10 ratio; writable
// - Step by decimal digit or standard list
// - Phase offsets left tone against right tone
// - Both lobe tone frequencies independently programmable
// - Enable switches the ident tone
// - Ident keyed in Morse; no code: key down
// - Ident frequency, period and depth programmable
// - Standard timing: dash, gaps from dot length
// - User timing: own dash and symbol space
// - User timing: own letter space length
module ltm_localizer_tone_modulator
  import ltm_pkg::*;
#(
  parameter int MS_TICK_CYCLES = TICK_CYCLES  // Clocks per keyer time unit
)(
  input  wire logic                    mclk,          // 125 MHz sample clock
  input  wire logic                    rst,           // Sync reset, active high
  input  wire ltm_mode_t               mode,          // Operating mode
  input  wire logic                    fly_right,     // Steer right, else left
  input  wire logic                    polarity_alt,  // Difference as 150 minus 90
  input  wire logic                    coupled,       // Difference follows sum in dB
  input  wire logic                    sdm_wr,        // Write sum_of_depths
  input  wire logic [DEPTH_W-1:0]      sdm_val,       // Sum, 0.01 % units
  input  wire logic                    ddm_wr,        // Write depth_difference
  input  wire logic [DEPTH_W-1:0]      ddm_val,       // Magnitude, 0.01 % units
  input  wire logic                    cur_wr,        // Write indicator current
  input  wire logic [CUR_W-2:0]        cur_val,       // Magnitude, 0.01 uA units
  input  wire logic                    db_wr,         // Write difference in dB
  input  wire logic [DEPTH_W-1:0]      db_val,        // Magnitude, 0.01 dB units
  input  wire logic                    step_predef,   // Step through list
  input  wire logic [1:0]              step_digit,    // Decimal digit, 0.01 % base
  input  wire logic                    step_up,       // Step up pulse
  input  wire logic                    step_down,     // Step down pulse
  input  wire ltm_lobe_cfg_t           lobe,          // Lobe tone settings
  input  wire ltm_ident_cfg_t          ident,         // ident_tone settings
  output logic signed [OUT_W-1:0]      mod_sample,    // Modulation, 0.01 % units
  output logic [DEPTH_W-1:0]           depth_left,    // 90 Hz depth in use
  output logic [DEPTH_W-1:0]           depth_right,   // 150 Hz depth in use
  output logic signed [DEPTH_W:0]      ddm_signed,    // Signed depth_difference
  output logic signed [CUR_W-1:0]      ddm_current,   // Signed indicator current
  output logic signed [DEPTH_W:0]      ddm_db,        // Signed difference in dB
  output logic                         ident_key,     // Morse key state
  output logic                         solve_busy     // dB solve in progress
);
  typedef enum logic {
    SV_IDLE = 1'b0,
    SV_RUN  = 1'b1
  } ltm_solve_state_t;

  logic [DEPTH_W-1:0] sdm_reg;
  logic [DEPTH_W-1:0] mag_reg;
  logic [DEPTH_W-1:0] db_reg;
  logic [CUR_W-2:0]   cur_reg;
  logic [1:0]         step_idx_reg;
  ltm_solve_state_t   sv_state_reg;
  logic [DEPTH_W-1:0] sv_res_reg;
  logic [DEPTH_W-1:0] sv_res_next;
  logic [3:0]         sv_bit_reg;
  logic [DEPTH_W-1:0] sv_target_reg;
  logic [DEPTH_W-1:0] trial;
  logic               sv_start;
  logic               sv_abort;
  logic               sv_done;
  logic [ACC_W-1:0]   acc_left_reg;
  logic [ACC_W-1:0]   acc_right_reg;
  logic [ACC_W-1:0]   acc_id_reg;
  logic [ACC_W-1:0]   ph_left;
  logic [TICK_W-1:0]  tick_cnt_reg;
  logic               tick;
  logic               key;
  logic               positive;
  logic [DEPTH_W-1:0] mag_eff;
  logic [DEPTH_W:0]   hi_sum;
  logic [DEPTH_W:0]   lo_sum;
  logic [DEPTH_W-1:0] d_left_next;
  logic [DEPTH_W-1:0] d_right_next;
  logic [DEPTH_W-1:0] d_id_next;
  logic [DEPTH_W-1:0] step_amt;
  logic [DEPTH_W:0]   step_sum;
  logic [SUM_W-1:0]   sum_next;
  logic [CUR_W+15:0]  cur_prod;
  logic [CUR_W+15:0]  inv_prod;

  // log2 in Q5.8 by leading one and linear mantissa
  function automatic logic [12:0] log2q(input logic [DEPTH_W:0] x);
    logic [4:0]       p;
    logic [DEPTH_W:0] n;
    p = 5'h00;
    for (int i = 0; i <= LOG_MSB; i++) begin
      if (x[i]) begin
        p = 5'(i);
      end
    end
    n = x << (5'(LOG_MSB) - p);
    log2q = {p, n[LOG_MSB-1 -: LOG_FRAC]};
  endfunction

  // Difference in 0.01 dB for a given sum and magnitude
  function automatic logic [DEPTH_W-1:0] db_of(input logic [DEPTH_W-1:0] s,
                                               input logic [DEPTH_W-1:0] m);
    logic [DEPTH_W:0] a;
    logic [DEPTH_W:0] b;
    logic [28:0]      prod;
    a = {1'b0, s} + {1'b0, m};
    b = {1'b0, s} - {1'b0, m};
    prod = 29'(log2q(a) - log2q(b)) * 29'(LTM_DB_MUL);
    if (m == '0) begin
      db_of = '0;
    end else if (m >= s) begin
      db_of = LTM_DB_MAX;
    end else begin
      db_of = prod[DB_SHIFT +: DEPTH_W];
    end
  endfunction

  // Depth times sine sample, 0.01 % scaled by the sine gain
  function automatic logic signed [28:0] weight(input logic [DEPTH_W-1:0] d,
                                                input logic [ACC_W-1:0] ph);
    weight = $signed({1'b0, d}) * ltm_sine(ph[ACC_W-1 -: PH_IDX_W]);
  endfunction

  // Time unit divider for the Morse keyer
  always_ff @(posedge mclk) begin
    if (rst || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end
  assign tick = tick_cnt_reg == TICK_W'(MS_TICK_CYCLES - 1);

  // Sum of depths: changing it never touches the magnitude directly
  always_ff @(posedge mclk) begin
    if (rst) begin
      sdm_reg <= '0;
    end else if (sdm_wr) begin
      sdm_reg <= sdm_val;
    end
  end

  // Decimal step size from the chosen digit
  always_comb begin
    case (step_digit)
      2'h0:    step_amt = 16'h0001;
      2'h1:    step_amt = 16'h000A;
      2'h2:    step_amt = 16'h0064;
      default: step_amt = 16'h03E8;
    endcase
  end
  assign step_sum = step_up ? {1'b0, mag_reg} + {1'b0, step_amt}
                            : {1'b0, mag_reg} - {1'b0, step_amt};

  // Current to magnitude, reciprocal multiply avoids a divider
  assign inv_prod = {16'h0000, cur_val} * {CUR_W'(0), LTM_CUR_INV};
  assign cur_prod = {CUR_W'(0), mag_reg} * {CUR_W'(0), LTM_CUR_MUL};

  // Any direct write of the difference cancels a pending solve
  assign sv_abort = ddm_wr || cur_wr || step_up || step_down;
  assign sv_start = !sv_abort && (db_wr || (sdm_wr && coupled));
  assign trial    = sv_res_reg | (16'h0001 << sv_bit_reg);
  assign sv_done  = sv_state_reg == SV_RUN && sv_bit_reg == '0;

  // Keep the trial bit only while its dB stays at or below target
  always_comb begin
    sv_res_next = sv_res_reg;
    if (trial < sdm_reg && db_of(sdm_reg, trial) <= sv_target_reg) begin
      sv_res_next = trial;
    end
  end

  // Difference magnitude, last writer wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      mag_reg <= '0;
    end else if (ddm_wr) begin
      mag_reg <= ddm_val;
    end else if (cur_wr) begin
      mag_reg <= inv_prod[CUR_INV_SHIFT +: DEPTH_W];
    end else if (step_up || step_down) begin
      if (step_predef) begin
        mag_reg <= LTM_STEP_LIST[step_up ? ((step_idx_reg == LTM_STEP_LAST) ?
                   step_idx_reg : step_idx_reg + 2'h1) :
                   ((step_idx_reg == '0) ? step_idx_reg : step_idx_reg - 2'h1)];
      end else if (step_sum[DEPTH_W] || step_sum[DEPTH_W-1:0] > LTM_FULL_DEPTH) begin
        mag_reg <= step_up ? LTM_FULL_DEPTH : '0;
      end else begin
        mag_reg <= step_sum[DEPTH_W-1:0];
      end
    end else if (sv_done) begin
      mag_reg <= sv_res_next;
    end
  end

  // Position in the standard list
  always_ff @(posedge mclk) begin
    if (rst) begin
      step_idx_reg <= '0;
    end else if (step_predef && step_up && step_idx_reg != LTM_STEP_LAST) begin
      step_idx_reg <= step_idx_reg + 2'h1;
    end else if (step_predef && step_down && step_idx_reg != '0) begin
      step_idx_reg <= step_idx_reg - 2'h1;
    end
  end

  // Bitwise search for the magnitude that meets the dB target
  always_ff @(posedge mclk) begin
    if (rst || sv_abort) begin
      sv_state_reg  <= SV_IDLE;
      sv_res_reg    <= '0;
      sv_bit_reg    <= LTM_SOLVE_TOP;
      sv_target_reg <= '0;
    end else if (sv_start) begin
      sv_state_reg  <= SV_RUN;
      sv_res_reg    <= '0;
      sv_bit_reg    <= LTM_SOLVE_TOP;
      sv_target_reg <= db_wr ? db_val : db_reg;
    end else if (sv_state_reg == SV_RUN) begin
      sv_res_reg <= sv_res_next;
      sv_bit_reg <= sv_bit_reg - 4'h1;
      if (sv_done) begin
        sv_state_reg <= SV_IDLE;
      end
    end
  end
  assign solve_busy = sv_state_reg == SV_RUN;

  // Derived views of the difference, refreshed every cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      db_reg  <= '0;
      cur_reg <= '0;
    end else begin
      db_reg  <= db_of(sdm_reg, mag_reg);
      cur_reg <= cur_prod[CUR_SHIFT +: CUR_W-1];
    end
  end

  // Sign: right steering is positive, alternate polarity negates
  assign positive = fly_right ^ polarity_alt;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ddm_signed  <= '0;
      ddm_current <= '0;
      ddm_db      <= '0;
    end else begin
      ddm_signed  <= positive ? $signed({1'b0, mag_reg}) : -$signed({1'b0, mag_reg});
      ddm_current <= positive ? $signed({1'b0, cur_reg}) : -$signed({1'b0, cur_reg});
      ddm_db      <= positive ? $signed({1'b0, db_reg}) : -$signed({1'b0, db_reg});
    end
  end

  // Larger and smaller lobe depth; magnitude clipped to the sum
  assign mag_eff = (mag_reg > sdm_reg) ? sdm_reg : mag_reg;
  assign hi_sum  = {1'b0, sdm_reg} + {1'b0, mag_eff};
  assign lo_sum  = {1'b0, sdm_reg} - {1'b0, mag_eff};

  // Per-mode tone depths; single-tone modes drop the ident tone
  always_comb begin
    d_left_next  = '0;
    d_right_next = '0;
    d_id_next    = '0;
    case (mode)
      LTM_MODE_LEFT: begin
        d_left_next = fly_right ? hi_sum[DEPTH_W:1] : lo_sum[DEPTH_W:1];
      end
      LTM_MODE_RIGHT: begin
        d_right_next = fly_right ? hi_sum[DEPTH_W:1] : lo_sum[DEPTH_W:1];
      end
      default: begin
        d_left_next  = fly_right ? hi_sum[DEPTH_W:1] : lo_sum[DEPTH_W:1];
        d_right_next = fly_right ? lo_sum[DEPTH_W:1] : hi_sum[DEPTH_W:1];
        if (ident.en && key) begin
          d_id_next = ident.depth;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      depth_left  <= '0;
      depth_right <= '0;
    end else begin
      depth_left  <= d_left_next;
      depth_right <= d_right_next;
    end
  end

  // Free-running tone accumulators, one sample per clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_left_reg  <= '0;
      acc_right_reg <= '0;
      acc_id_reg    <= '0;
    end else begin
      acc_left_reg  <= acc_left_reg + lobe.left_inc;
      acc_right_reg <= acc_right_reg + lobe.right_inc;
      acc_id_reg    <= acc_id_reg + ident.inc;
    end
  end

  // Both lobes start together at reset, so the offset holds against right zero
  assign ph_left = acc_left_reg + {lobe.phase, 16'h0000};

  // Weighted sum; sine gain of 2^11 is removed in the slice
  assign sum_next = SUM_W'(weight(depth_left, ph_left)) +
                    SUM_W'(weight(depth_right, acc_right_reg)) +
                    SUM_W'(weight(d_id_next, acc_id_reg));

  always_ff @(posedge mclk) begin
    if (rst) begin
      mod_sample <= '0;
    end else begin
      mod_sample <= sum_next[SIN_SHIFT +: OUT_W];
    end
  end

  // Morse keying of the ident tone
  ltm_morse_keyer u_keyer (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick),
    .cfg  (ident),
    .key  (key)
  );
  assign ident_key = key;
endmodule

// ### test/ltm_chk.sv
// Port checker for the localizer tone modulator
module ltm_chk import ltm_pkg::*; (
  input wire logic                    mclk,         // Clock
  input wire logic                    rst,          // Reset
  input wire ltm_mode_t               mode,         // Mode
  input wire logic                    fly_right,    // Steer
  input wire logic                    polarity_alt, // Sense
  input wire logic                    db_wr,        // dB write
  input wire ltm_ident_cfg_t          ident,        // Ident
  input wire logic [DEPTH_W-1:0]      depth_left,   // Left
  input wire logic [DEPTH_W-1:0]      depth_right,  // Right
  input wire logic signed [DEPTH_W:0] ddm_signed,   // Diff
  input wire logic signed [CUR_W-1:0] ddm_current,  // Current
  input wire logic                    ident_key,    // Key
  input wire logic                    solve_busy    // Busy
);
  // Settled values only: the depth, sign, current and key antecedents wait out the update latency
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_lo; (mode == LTM_MODE_LEFT)[*3] |=> depth_right == 0; endproperty
  a_lo: assert property (p_lo) else $error("right depth in left mode");
  property p_ro; (mode == LTM_MODE_RIGHT)[*3] |=> depth_left == 0; endproperty
  a_ro: assert property (p_ro) else $error("left depth in right mode");
  property p_dom; (mode == LTM_MODE_NORM && $stable(fly_right))[*3]
    |=> ($past(fly_right) ? depth_left >= depth_right : depth_right >= depth_left); endproperty
  a_dom: assert property (p_dom) else $error("wrong dominant tone");
  property p_sign; ($stable(fly_right) && $stable(polarity_alt))[*3] ##0 ddm_signed != 0
    |-> ddm_signed[DEPTH_W] == !(fly_right ^ polarity_alt); endproperty
  a_sign: assert property (p_sign) else $error("difference sign");
  property p_cur; $stable(ddm_signed)[*4] |-> (ddm_current < 0) == (ddm_signed < 0); endproperty
  a_cur: assert property (p_cur) else $error("current sign");
  property p_key; (ident.code == 0)[*4] |-> ident_key; endproperty
  a_key: assert property (p_key) else $error("key not down without code");
  property p_solve; db_wr |=> solve_busy[*8]; endproperty
  a_solve: assert property (p_solve) else $error("dB solve not started");
  property p_slen; $rose(solve_busy) |-> solve_busy[*8] ##7 solve_busy ##[1:2] !solve_busy;
  endproperty
  a_slen: assert property (p_slen) else $error("dB solve length");
endmodule

bind ltm_localizer_tone_modulator ltm_chk i_ltm_chk (.*);

// ### test/test_localizer_tone_modulator.sv
// Self-checking bench for the localizer tone modulator
module test_localizer_tone_modulator
  import ltm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, fly_right = 0, polarity_alt = 0, coupled = 0, step_predef = 0;
  logic sdm_wr = 0, ddm_wr = 0, cur_wr = 0, db_wr = 0, step_up = 0, step_down = 0;
  logic        [15:0] sdm_val = 0, ddm_val = 0, db_val = 0, depth_left, depth_right;
  logic        [23:0] cur_val = 0;
  logic        [1:0]  step_digit = 0;
  ltm_mode_t          mode = LTM_MODE_NORM;
  ltm_lobe_cfg_t      lobe = '0;
  ltm_ident_cfg_t     ident = '0;
  logic signed [15:0] mod_sample;
  logic signed [16:0] ddm_signed, ddm_db;
  logic signed [24:0] ddm_current;
  logic               ident_key, solve_busy;
  int                 mismatches = 0, n_compared = 0, s, d, t, sd, el, er;
  logic        [31:0] n_cyc = 0;
  real                r;

  ltm_localizer_tone_modulator #(.MS_TICK_CYCLES(8)) i_ltm_localizer_tone_modulator (.*);

  // Clock, 8 ns period
  always #4 mclk = ~mclk;

  // Edges since reset, counted the way the tone accumulators count them
  always @(posedge mclk) n_cyc <= rst ? 32'h0000_0000 : n_cyc + 32'h0000_0001;

  // Depth times sine at a tone's top six phase bits, taken mid-step
  function automatic real tone(int dep, logic [31:0] inc, logic [15:0] ph);
    logic [31:0] a;
    a = (n_cyc - 32'h0000_0001) * inc + {ph, 16'h0000};
    return dep * $sin(6.283185307 * (a[31:26] + 0.5) / 64.0);
  endfunction

  // Compare within a tolerance; unknowns never pass
  task automatic chk(string w, int e, logic signed [31:0] g, int tol = 0);
    n_compared++;
    if ((g >= e - tol && g <= e + tol) !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask

  // One pulse: 0 sum, 1 diff, 2 current, 3 dB, 4 step up, 5 step down
  task automatic wr(int k, int v);
    {sdm_wr, ddm_wr, cur_wr, db_wr, step_up, step_down} <= 6'h20 >> k;
    {sdm_val, ddm_val, db_val, cur_val} <= {v[15:0], v[15:0], v[15:0], v[23:0]};
    @(posedge mclk);
    {sdm_wr, ddm_wr, cur_wr, db_wr, step_up, step_down} <= 6'h00;
    repeat (3) @(posedge mclk);
    for (t = 0; solve_busy === 1'b1 && t < 40; t++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  // Restart the keyer, then find the longest mark and shortest gap
  task automatic key(logic u, logic [19:0] c, int mk, int gp);
    int  run, hi, lo;
    logic k;
    ident.en <= 0;
    ident.user_schema <= u;
    ident.code <= c;
    repeat (4) @(posedge mclk);
    ident.en <= 1;
    run = -5000;
    hi = 0;
    lo = 9999;
    k = ident_key;
    repeat (1100) begin
      @(posedge mclk);
      run++;
      if (ident_key !== k) begin
        if (k && run > hi) hi = run;
        if (!k && run > 0 && run < lo) lo = run;
        k = ident_key;
        run = 0;
      end
    end
    chk("mark", mk * 8, hi, 1);
    chk("gap", gp * 8, lo, 1);
  endtask

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    t = $urandom(32'h1da4);
    lobe <= {$urandom, $urandom, 16'h4000};
    repeat (2) @(posedge mclk);
    rst <= 0;
    chk("reset depth", 0, depth_left | depth_right | mod_sample | solve_busy);
    chk("reset diff", 0, ddm_signed | ddm_db | ddm_current | ident_key);
    for (int m = 0; m < 12; m++) begin
      s = 1000 + $urandom % 7000;
      d = m == 0 ? 0 : m == 11 ? s - 1 : $urandom % s;
      mode <= ltm_mode_t'(m / 4);
      {fly_right, polarity_alt} <= 2'(m);
      wr(0, s);
      wr(1, d);
      sd = (fly_right ^ polarity_alt) ? d : -d;
      el = m / 4 == 2 ? 0 : fly_right ? (s + d) / 2 : (s - d) / 2;
      er = m / 4 == 1 ? 0 : (fly_right ^ (m / 4 == 0)) ? (s + d) / 2 : (s - d) / 2;
      r = tone(el, lobe.left_inc, lobe.phase) + tone(er, lobe.right_inc, 16'h0000);
      chk("signed", sd, ddm_signed);
      chk("left", el, depth_left);
      chk("right", er, depth_right);
      chk("current", sd * 96775 / 10000, ddm_current, 2 + d / 500);
      chk("sample", int'(r), mod_sample, 2 + (el + er) / 150);
    end
    $display("test depths done");
    mode <= LTM_MODE_NORM;
    {fly_right, polarity_alt} <= 2'b10;
    wr(0, 4000);
    wr(1, 1200);
    chk("db", int'(2000 * $log10(5200.0 / 2800.0)), ddm_db, 60);
    wr(0, 6000);
    chk("fixed", 1200, ddm_signed);
    coupled <= 1;
    wr(0, 3000);
    chk("coupled", 1200 * 3000 / 6000, ddm_signed, 60);
    coupled <= 0;
    wr(3, 600);
    r = 10.0 ** 0.3;
    chk("solve", int'(3000 * (r - 1) / (r + 1)), ddm_signed, 100);
    wr(2, 20000);
    chk("from current", 20000 * 10000 / 96775, ddm_signed, 20);
    wr(1, 1000);
    step_digit <= 2'h1;
    wr(4, 0);
    chk("decimal", 1010, ddm_signed);
    step_digit <= 2'h3;
    wr(5, 0);
    chk("decimal down", 10, ddm_signed);
    step_predef <= 1;
    wr(1, 0);
    for (int i = 1; i < STEP_N; i++) begin
      wr(4, 0);
      chk("list", LTM_STEP_LIST[i], ddm_signed);
    end
    wr(5, 0);
    chk("list down", LTM_STEP_LIST[2], ddm_signed);
    $display("test difference done");
    // Sum plus ident depth kept under full scale
    ident <= '{1'b1, 1'b0, 20'h0_0000, 10'h003, 10'h005, 10'h004, 10'h007,
               16'h003C, 16'h03E8, 32'h0400_0000};
    @(posedge mclk);
    key(0, 20'h000A5, 3, 9);
    key(0, 20'h00009, 3, 3);
    key(0, 20'h000B4, 9, 9);
    key(1, 20'h000B4, 5, 7);
    key(1, 20'h00009, 3, 4);
    $display("test keyer done");
    end_of_test();
  end

  // Watchdog, far beyond the expected run length
  initial begin
    #400_000;
    mismatches++;
    end_of_test();
  end
endmodule
